// >>> inc/ddr_host_pkg.sv
// constants, register map and types for the dram pin-level host controller
// assumes one ahb-lite master and one x8 dram on the pins
package ddr_host_pkg;
   // own register map, byte addresses
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] ADDR_OFS = 8'h04;
   localparam logic [7:0] CMD_OFS  = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0C;
   localparam logic [7:0] WLO_OFS  = 8'h10;
   localparam logic [7:0] WHI_OFS  = 8'h14;
   localparam logic [7:0] RLO_OFS  = 8'h18;
   localparam logic [7:0] RHI_OFS  = 8'h1C;
   localparam logic [7:0] MASK_OFS = 8'h20;
   // control bits
   localparam int CTRL_RST_BIT = 0;
   localparam int CTRL_CKE_BIT = 1;
   localparam int CTRL_ODT_BIT = 2;
   localparam int CTRL_OTF_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   // address register fields
   localparam int ADDR_BA_POS  = 16;
   localparam int ADDR_A12_POS = 12;
   // status bits
   localparam int STAT_ERR_BIT = 2;
   // burst lengths in beats
   localparam logic [3:0] BEATS_FULL = 4'h8;
   localparam logic [3:0] BEATS_CHOP = 4'h4;
   // link clock from the bus clock
   localparam int HCLK_NS      = 50;
   localparam int CK_PERIOD_NS = 400;
   localparam int CK_HALF_CYC  = CK_PERIOD_NS / (2 * HCLK_NS);
   // {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] PINS_DESEL = 4'hF;
   localparam logic [3:0] PINS_NOP   = 4'h7;
   localparam logic [3:0] PINS_ACT   = 4'h3;
   localparam logic [3:0] PINS_RD    = 4'h5;
   localparam logic [3:0] PINS_WR    = 4'h4;
   localparam logic [3:0] PINS_PRE   = 4'h2;
   localparam logic [3:0] PINS_MRS   = 4'h0;
   localparam logic [3:0] PINS_REF   = 4'h1;
   typedef enum logic [2:0] {C_NOP, C_ACT, C_RD, C_WR, C_PRE, C_MRS, C_REF} cmd_type;
   typedef enum {S_IDLE, S_HOLD, S_WR, S_RD} state_type;
endpackage

// >>> rtl/ddr_host_ctrl.sv
// host-side controller driving a dram over its command, address and data pins
// assumes an ahb-lite master for the own registers and an x8 dram on the pins
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
module ddr_host_ctrl #(
   parameter int CK_HALF = ddr_host_pkg::CK_HALF_CYC
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // dram clock, reset and control
   output logic             ck_o,
   output logic             ck_n_o,
   output logic             mem_reset_n,
   output logic             cke,
   output logic             odt,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic      [15:0] addr,
   output logic      [2:0]  ba,
   output logic             dm,
   // dram data, enables active low
   input  wire logic [7:0]  dq_i,
   output logic      [7:0]  dq_o,
   output logic             dq_oe_n,
   input  wire logic        dqs_i,
   output logic             dqs_o,
   output logic             dqs_n_o,
   output logic             dqs_oe_n
);
   logic [7:0]  cnt_reg, cnt_next;
   logic        ck_reg, ck_next;
   ddr_host_pkg::state_type st_reg, st_next;
   ddr_host_pkg::cmd_type   cmd_reg, cmd_next;
   logic        pend_reg, pend_next;
   logic [3:0]  pins_reg, pins_next;
   logic [15:0] a_reg, a_next;
   logic [2:0]  ba_reg, ba_next;
   logic [7:0]  dq_reg, dq_next;
   logic        dqoe_reg, dqoe_next;
   logic        dqs_reg, dqs_next;
   logic        dqsoe_reg, dqsoe_next;
   logic        dm_reg, dm_next;
   logic [2:0]  beat_reg, beat_next;
   logic [3:0]  nb_reg, nb_next;
   logic [63:0] rdat_reg, rdat_next;
   logic [63:0] wdat_reg, wdat_next;
   logic [7:0]  mask_reg, mask_next;
   logic        done_reg, done_next;
   logic        err_reg, err_next;
   logic [3:0]  ctrl_reg, ctrl_next;
   logic [18:0] areg_reg, areg_next;
   logic [7:0]  pha_reg, pha_next;
   logic        phw_reg, phw_next;
   logic [31:0] hrd_reg, hrd_next;
   logic        dqs_s1, dqs_s2, dqs_s3, dedge_d;
   logic [7:0]  dq_s1, dq_s2;
   logic        edge_t, fall, mid, busy;
   logic [2:0]  binc;

   function automatic logic [3:0] enc(input ddr_host_pkg::cmd_type c);
      case (c)
         ddr_host_pkg::C_ACT: enc = ddr_host_pkg::PINS_ACT;
         ddr_host_pkg::C_RD:  enc = ddr_host_pkg::PINS_RD;
         ddr_host_pkg::C_WR:  enc = ddr_host_pkg::PINS_WR;
         ddr_host_pkg::C_PRE: enc = ddr_host_pkg::PINS_PRE;
         ddr_host_pkg::C_MRS: enc = ddr_host_pkg::PINS_MRS;
         ddr_host_pkg::C_REF: enc = ddr_host_pkg::PINS_REF;
         default:             enc = ddr_host_pkg::PINS_NOP;
      endcase
   endfunction

   assign edge_t = cnt_reg == 8'(CK_HALF - 1);
   assign fall   = edge_t && ck_reg;
   assign mid    = cnt_reg == 8'(CK_HALF / 2 - 1);
   assign busy   = (st_reg != ddr_host_pkg::S_IDLE) || pend_reg;
   assign binc   = beat_reg + 3'h1;

   always_comb begin
      cnt_next   = edge_t ? 8'h00 : cnt_reg + 8'h01;
      ck_next    = edge_t ? ~ck_reg : ck_reg;
      st_next    = st_reg;
      cmd_next   = cmd_reg;
      pend_next  = pend_reg;
      pins_next  = pins_reg;
      a_next     = a_reg;
      ba_next    = ba_reg;
      dq_next    = dq_reg;
      dqoe_next  = dqoe_reg;
      dqs_next   = dqs_reg;
      dqsoe_next = dqsoe_reg;
      dm_next    = dm_reg;
      beat_next  = beat_reg;
      nb_next    = nb_reg;
      rdat_next  = rdat_reg;
      wdat_next  = wdat_reg;
      mask_next  = mask_reg;
      done_next  = done_reg;
      err_next   = err_reg;
      ctrl_next  = ctrl_reg;
      areg_next  = areg_reg;
      pha_next   = pha_reg;
      phw_next   = 1'b0;
      hrd_next   = hrd_reg;
      // address phase; read data prepared here so it leaves a flop
      if (hsel && htrans[1] && hready) begin
         pha_next = haddr[7:0];
         phw_next = hwrite;
         case (haddr[7:0])
            ddr_host_pkg::CTRL_OFS: hrd_next = {28'h0000000, ctrl_reg};
            ddr_host_pkg::ADDR_OFS: hrd_next = {13'h0000, areg_reg};
            ddr_host_pkg::STAT_OFS: hrd_next = {29'h00000000, err_reg, done_reg, busy};
            ddr_host_pkg::WLO_OFS:  hrd_next = wdat_reg[31:0];
            ddr_host_pkg::WHI_OFS:  hrd_next = wdat_reg[63:32];
            ddr_host_pkg::RLO_OFS:  hrd_next = rdat_reg[31:0];
            ddr_host_pkg::RHI_OFS:  hrd_next = rdat_reg[63:32];
            ddr_host_pkg::MASK_OFS: hrd_next = {24'h000000, mask_reg};
            default:                hrd_next = 32'h00000000;
         endcase
      end
      // write data phase
      if (phw_reg) begin
         case (pha_reg)
            ddr_host_pkg::CTRL_OFS: ctrl_next = hwdata[3:0];
            ddr_host_pkg::ADDR_OFS: areg_next = hwdata[18:0];
            ddr_host_pkg::WLO_OFS:  wdat_next[31:0] = hwdata;
            ddr_host_pkg::WHI_OFS:  wdat_next[63:32] = hwdata;
            ddr_host_pkg::MASK_OFS: mask_next = hwdata[7:0];
            ddr_host_pkg::STAT_OFS: if (hwdata[ddr_host_pkg::STAT_ERR_BIT]) err_next = 1'b0;
            ddr_host_pkg::CMD_OFS: begin
               // a command while one is in flight is dropped and flagged
               if (busy) begin
                  err_next = 1'b1;
               end else begin
                  cmd_next  = ddr_host_pkg::cmd_type'(hwdata[2:0]);
                  pend_next = 1'b1;
                  done_next = 1'b0;
               end
            end
            default: ;
         endcase
      end
      case (st_reg)
         ddr_host_pkg::S_IDLE: begin
            // launch on the falling clock so pins settle before the rise
            if (pend_reg && fall) begin
               pins_next = enc(cmd_reg);
               a_next    = areg_reg[15:0];
               ba_next   = areg_reg[18:16];
               pend_next = 1'b0;
               nb_next   = (ctrl_reg[ddr_host_pkg::CTRL_OTF_BIT] && !areg_reg[ddr_host_pkg::ADDR_A12_POS])
                           ? ddr_host_pkg::BEATS_CHOP : ddr_host_pkg::BEATS_FULL;
               st_next   = ddr_host_pkg::S_HOLD;
            end
         end
         ddr_host_pkg::S_HOLD: begin
            if (fall) begin
               pins_next = ddr_host_pkg::PINS_DESEL;
               beat_next = 3'h0;
               if (cmd_reg == ddr_host_pkg::C_WR) begin
                  st_next    = ddr_host_pkg::S_WR;
                  dq_next    = wdat_reg[7:0];
                  dm_next    = mask_reg[0];
                  dqoe_next  = 1'b0;
                  dqs_next   = 1'b0;
                  dqsoe_next = 1'b0;
               end else if (cmd_reg == ddr_host_pkg::C_RD) begin
                  st_next = ddr_host_pkg::S_RD;
               end else begin
                  st_next   = ddr_host_pkg::S_IDLE;
                  done_next = 1'b1;
               end
            end
         end
         ddr_host_pkg::S_WR: begin
            // strobe toggles mid-beat, data changes on clock edges
            if (mid) dqs_next = ~dqs_reg;
            if (edge_t) begin
               if ({1'b0, beat_reg} == nb_reg - 4'h1) begin
                  st_next    = ddr_host_pkg::S_IDLE;
                  dqoe_next  = 1'b1;
                  dqsoe_next = 1'b1;
                  dm_next    = 1'b0;
                  done_next  = 1'b1;
               end else begin
                  beat_next = binc;
                  dq_next   = wdat_reg[{binc, 3'b000} +: 8];
                  dm_next   = mask_reg[binc];
               end
            end
         end
         ddr_host_pkg::S_RD: begin
            // sample one cycle after the synced strobe edge, away from the data change
            if (dedge_d) begin
               rdat_next[{beat_reg, 3'b000} +: 8] = dq_s2;
               if ({1'b0, beat_reg} == nb_reg - 4'h1) begin
                  st_next   = ddr_host_pkg::S_IDLE;
                  done_next = 1'b1;
               end else begin
                  beat_next = binc;
               end
            end
         end
         default: st_next = ddr_host_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg   <= 8'h00;
         ck_reg    <= 1'b0;
         st_reg    <= ddr_host_pkg::S_IDLE;
         cmd_reg   <= ddr_host_pkg::C_NOP;
         pend_reg  <= 1'b0;
         pins_reg  <= ddr_host_pkg::PINS_DESEL;
         a_reg     <= 16'h0000;
         ba_reg    <= 3'h0;
         dq_reg    <= 8'h00;
         dqoe_reg  <= 1'b1;
         dqs_reg   <= 1'b0;
         dqsoe_reg <= 1'b1;
         dm_reg    <= 1'b0;
         beat_reg  <= 3'h0;
         nb_reg    <= ddr_host_pkg::BEATS_FULL;
         rdat_reg  <= 64'h0000000000000000;
         wdat_reg  <= 64'h0000000000000000;
         mask_reg  <= 8'h00;
         done_reg  <= 1'b0;
         err_reg   <= 1'b0;
         ctrl_reg  <= ddr_host_pkg::CTRL_RESET;
         areg_reg  <= 19'h00000;
         pha_reg   <= 8'h00;
         phw_reg   <= 1'b0;
         hrd_reg   <= 32'h00000000;
         dqs_s1    <= 1'b0;
         dqs_s2    <= 1'b0;
         dqs_s3    <= 1'b0;
         dedge_d   <= 1'b0;
         dq_s1     <= 8'h00;
         dq_s2     <= 8'h00;
      end else begin
         cnt_reg   <= cnt_next;
         ck_reg    <= ck_next;
         st_reg    <= st_next;
         cmd_reg   <= cmd_next;
         pend_reg  <= pend_next;
         pins_reg  <= pins_next;
         a_reg     <= a_next;
         ba_reg    <= ba_next;
         dq_reg    <= dq_next;
         dqoe_reg  <= dqoe_next;
         dqs_reg   <= dqs_next;
         dqsoe_reg <= dqsoe_next;
         dm_reg    <= dm_next;
         beat_reg  <= beat_next;
         nb_reg    <= nb_next;
         rdat_reg  <= rdat_next;
         wdat_reg  <= wdat_next;
         mask_reg  <= mask_next;
         done_reg  <= done_next;
         err_reg   <= err_next;
         ctrl_reg  <= ctrl_next;
         areg_reg  <= areg_next;
         pha_reg   <= pha_next;
         phw_reg   <= phw_next;
         hrd_reg   <= hrd_next;
         dqs_s1    <= dqs_i;
         dqs_s2    <= dqs_s1;
         dqs_s3    <= dqs_s2;
         dedge_d   <= dqs_s2 ^ dqs_s3;
         dq_s1     <= dq_i;
         dq_s2     <= dq_s1;
      end
   end

   assign hrdata      = hrd_reg;
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign ck_o        = ck_reg;
   assign ck_n_o      = ~ck_reg;
   assign mem_reset_n = ctrl_reg[ddr_host_pkg::CTRL_RST_BIT];
   assign cke         = ctrl_reg[ddr_host_pkg::CTRL_CKE_BIT];
   assign odt         = ctrl_reg[ddr_host_pkg::CTRL_ODT_BIT];
   assign {cs_n, ras_n, cas_n, we_n} = pins_reg;
   assign addr        = a_reg;
   assign ba          = ba_reg;
   assign dm          = dm_reg;
   assign dq_o        = dq_reg;
   assign dq_oe_n     = dqoe_reg;
   assign dqs_o       = dqs_reg;
   assign dqs_n_o     = ~dqs_reg;
   assign dqs_oe_n    = dqsoe_reg;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_pins_on_fall;
      !$stable(pins_reg) |-> $past(fall);
   endproperty
   a_pins_on_fall: assert property (p_pins_on_fall) else $error("command pins moved off the falling clock");

   property p_stable_rise;
      $rose(ck_reg) |-> $stable(pins_reg) && $stable(a_reg) && $stable(ba_reg);
   endproperty
   a_stable_rise: assert property (p_stable_rise) else $error("pins changed at clock rise");

   property p_desel_idle;
      st_reg == ddr_host_pkg::S_IDLE |-> cs_n;
   endproperty
   a_desel_idle: assert property (p_desel_idle) else $error("chip selected while idle");

   property p_cmd_addr;
      !cs_n |-> a_reg == areg_reg[15:0] && ba_reg == areg_reg[18:16];
   endproperty
   a_cmd_addr: assert property (p_cmd_addr) else $error("address or bank differs from register");

   property p_chop;
      st_reg == ddr_host_pkg::S_WR && nb_reg == ddr_host_pkg::BEATS_CHOP |-> beat_reg < 3'h4;
   endproperty
   a_chop: assert property (p_chop) else $error("chopped burst ran past four beats");

   property p_mask;
      st_reg == ddr_host_pkg::S_WR && mid |-> dm_reg == mask_reg[beat_reg] && dq_reg == wdat_reg[{beat_reg, 3'b000} +: 8];
   endproperty
   a_mask: assert property (p_mask) else $error("write beat or mask wrong");

   property p_strobe_mid;
      !dqsoe_reg && !$past(dqsoe_reg) && !$stable(dqs_reg) |-> $past(mid);
   endproperty
   a_strobe_mid: assert property (p_strobe_mid) else $error("write strobe not centred");

   property p_release;
      st_reg != ddr_host_pkg::S_WR |-> dqoe_reg && dqsoe_reg;
   endproperty
   a_release: assert property (p_release) else $error("data driven outside a write");

   property p_wr_follow;
      st_reg == ddr_host_pkg::S_HOLD && cmd_reg == ddr_host_pkg::C_WR && fall |=> !dq_oe_n && dq_o == wdat_reg[7:0];
   endproperty
   a_wr_follow: assert property (p_wr_follow) else $error("write data not started after command");
endmodule

// >>> sim/ddr_dev_model.sv
// behavioural x8 dram that answers the host controller on its pins
// assumes ck from the controller and the bench resolving the shared dq and dqs lines
module ddr_dev_model (
   // clock, reset and control
   input  wire logic        ck,
   input  wire logic        reset_n,
   input  wire logic        cke,
   input  wire logic        odt,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic [15:0] addr,
   input  wire logic [2:0]  ba,
   input  wire logic        dm,
   // shared data lines as resolved
   input  wire logic [7:0]  dq_in,
   input  wire logic        dqs_in,
   input  wire logic        dqs_host_oe_n,
   // own drive, only seen while the host floats
   output logic      [7:0]  dq,
   output logic             dqs
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] BLANK    = 8'hEE;
   localparam int         HALF_NS  = 400;
   localparam int         TERM_BIT = 2;
   logic [15:0] mr [4];
   logic [15:0] row [8];
   logic [7:0]  open_b;
   logic [7:0]  mem [logic [31:0]];
   logic        pd;
   logic        term_on;
   logic [31:0] key;
   logic [31:0] wbase;
   int          lat = 600;
   int          wcnt = 0;
   int          wnb = 0;

   function automatic int beats(input logic a12);
      return (mr[0][0] && !a12) ? 4 : 8;
   endfunction

   // slow half periods so the host's two-flop capture sees stable data
   task automatic rd_burst(input logic [31:0] base, input int n);
      // start off the bus clock edge so the host's capture flops never race the change
      #(lat + 10);
      for (int i = 0; i < n; i++) begin
         dq = mem.exists(base + i) ? mem[base + i] : BLANK;
         dqs = ~dqs;
         #(HALF_NS);
      end
      dq = ~dq;
      dqs = ~dqs;
   endtask

   initial begin
      dq = 8'hA5;
      dqs = 1'b0;
   end

   always @(posedge ck or negedge reset_n) begin
      key = {3'b000, ba, row[ba], addr[9:0]};
      if (!reset_n) begin
         mr = '{default: 16'h0};
         open_b = 8'h00;
         pd = 1'b1;
         term_on = 1'b0;
      end else begin
         pd = !cke;
         term_on = odt && mr[1][TERM_BIT];
         if (cke) begin
            case ({cs_n, ras_n, cas_n, we_n})
               ddr_host_pkg::PINS_ACT: begin
                  row[ba] = addr;
                  open_b[ba] = 1'b1;
               end
               ddr_host_pkg::PINS_MRS: mr[ba[1:0]] = addr;
               ddr_host_pkg::PINS_PRE: open_b = addr[10] ? 8'h00 : open_b & ~(8'h01 << ba);
               ddr_host_pkg::PINS_WR: begin
                  wbase = key;
                  wcnt = 0;
                  wnb = beats(addr[12]);
               end
               ddr_host_pkg::PINS_RD: fork rd_burst(key, beats(addr[12])); join_none
               default: ;
            endcase
            if (!cs_n && ras_n && !cas_n && addr[10]) open_b[ba] = 1'b0;
         end
      end
   end

   // write beats taken on both strobe edges, strobe centred on data
   always @(dqs_in) begin
      if (!dqs_host_oe_n && wcnt < wnb) begin
         if (!dm) mem[wbase + wcnt] = dq_in;
         wcnt++;
      end
   end
endmodule

// >>> sim/sdram_command_pin_interface_tb.sv
// self-checking bench for the dram host controller with a behavioural dram
// assumes one ahb-lite master played by the bench and the x8 model on the pins
module sdram_command_pin_interface_tb;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(got, exp) begin \
   n_compared++; \
   if ((got) !== (exp)) begin \
      n_fail++; \
      $display("ERROR %0t: got %0h, expected %0h", $time, (got), (exp)); \
   end \
end
   typedef struct packed {logic [2:0] b; logic [15:0] op;} mode_row_type;
   localparam logic [31:0] B1 = {3'b000, 3'd3, 16'h1234, 10'h010};
   localparam logic [31:0] B2 = {3'b000, 3'd3, 16'h1234, 10'h020};
   mode_row_type rows [4] = '{'{3'd0, 16'h0001}, '{3'd1, 16'h0004}, '{3'd2, 16'h0ABC}, '{3'd3, 16'h0123}};
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, ck_o, ck_n_o, mem_reset_n, cke, odt, cs_n, ras_n, cas_n, we_n, dm;
   wire  [15:0] addr;
   wire  [2:0]  ba;
   wire  [7:0]  dq_o, m_dq, dq_bus;
   wire         dq_oe_n, dqs_o, dqs_n_o, dqs_oe_n, m_dqs, dqs_bus;
   int          n_fail = 0;
   int          n_compared = 0;
   int          cycles = 0;
   logic [31:0] q;
   logic [63:0] wdat;

   // shared lines: host drives when its enable is low, otherwise the model
   assign dq_bus  = dq_oe_n ? m_dq : dq_o;
   assign dqs_bus = dqs_oe_n ? m_dqs : dqs_o;

   ddr_host_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ck_o(ck_o), .ck_n_o(ck_n_o), .mem_reset_n(mem_reset_n),
      .cke(cke), .odt(odt), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .ba(ba),
      .dm(dm), .dq_i(dq_bus), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dqs_i(dqs_bus), .dqs_o(dqs_o),
      .dqs_n_o(dqs_n_o), .dqs_oe_n(dqs_oe_n));
   ddr_dev_model mdl (.ck(ck_o), .reset_n(mem_reset_n), .cke(cke), .odt(odt), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .addr(addr), .ba(ba), .dm(dm), .dq_in(dq_bus), .dqs_in(dqs_bus),
      .dqs_host_oe_n(dqs_oe_n), .dq(m_dq), .dqs(m_dqs));

   task automatic stop_test();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] j;
      ahb(1'b1, a, d, j);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      ahb(1'b0, a, 32'h0, r);
   endtask

   // done is polled, never assumed after a fixed time
   task automatic wait_done();
      logic [31:0] st;
      st = 32'h0;
      for (int k = 0; k < 400 && st[1] !== 1'b1; k++) rd(ddr_host_pkg::STAT_OFS, st);
      `CHK(st[1], 1'b1)
   endtask

   task automatic cmd_wait(input logic [2:0] c, input logic [31:0] ad);
      wr(ddr_host_pkg::ADDR_OFS, ad);
      wr(ddr_host_pkg::CMD_OFS, {29'h0, c});
      wait_done();
   endtask

   initial begin
      forever #25 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         stop_test();
      end
   end

   initial begin
      repeat (8) @(posedge hclk);
      `CHK({cs_n, ras_n, cas_n, we_n}, ddr_host_pkg::PINS_DESEL)
      `CHK({mem_reset_n, cke, odt}, 3'b000)
      `CHK({dq_oe_n, dqs_oe_n}, 2'b11)
      `CHK({hresp, dqs_o, dqs_n_o, ck_o, ck_n_o}, 5'b00101)
      hresetn <= 1'b1;
      wr(ddr_host_pkg::CTRL_OFS, 32'hF);
      rd(ddr_host_pkg::CTRL_OFS, q);
      `CHK(q[3:0], 4'hF)
      foreach (rows[i]) begin
         cmd_wait(ddr_host_pkg::C_MRS, {13'h0, rows[i].b, rows[i].op});
         `CHK(mdl.mr[rows[i].b[1:0]], rows[i].op)
      end
      cmd_wait(ddr_host_pkg::C_REF, 32'h0);
      cmd_wait(ddr_host_pkg::C_NOP, 32'h0);
      `CHK({mdl.term_on, mdl.pd}, 2'b10)
      `CHK(ck_n_o, ~ck_o)
      cmd_wait(ddr_host_pkg::C_ACT, 32'h0003_1234);
      cmd_wait(ddr_host_pkg::C_ACT, 32'h0001_00F0);
      `CHK(mdl.row[3], 16'h1234)
      `CHK(mdl.open_b, 8'h0A)
      wdat = 64'h7766554433221100;
      wr(ddr_host_pkg::WLO_OFS, wdat[31:0]);
      wr(ddr_host_pkg::WHI_OFS, wdat[63:32]);
      wr(ddr_host_pkg::MASK_OFS, 32'h04);
      cmd_wait(ddr_host_pkg::C_WR, 32'h0003_1010);
      for (int i = 0; i < 8; i++) begin
         if (i == 2) `CHK(mdl.mem.exists(B1 + i) != 0, 1'b0)
         else `CHK(mdl.mem[B1 + i], wdat[8*i +: 8])
      end
      // second command lands while the chopped write is busy
      wr(ddr_host_pkg::WLO_OFS, 32'hDDCCBBAA);
      wr(ddr_host_pkg::MASK_OFS, 32'h0);
      wr(ddr_host_pkg::ADDR_OFS, 32'h0003_0020);
      wr(ddr_host_pkg::CMD_OFS, {29'h0, ddr_host_pkg::C_WR});
      wr(ddr_host_pkg::CMD_OFS, {29'h0, ddr_host_pkg::C_PRE});
      wait_done();
      rd(ddr_host_pkg::STAT_OFS, q);
      `CHK(q[ddr_host_pkg::STAT_ERR_BIT], 1'b1)
      `CHK(mdl.open_b[3], 1'b1)
      for (int i = 0; i < 5; i++) `CHK(mdl.mem.exists(B2 + i) != 0, i < 4)
      wr(ddr_host_pkg::STAT_OFS, 32'h4);
      rd(ddr_host_pkg::STAT_OFS, q);
      `CHK(q[ddr_host_pkg::STAT_ERR_BIT], 1'b0)
      mdl.lat = 300;
      cmd_wait(ddr_host_pkg::C_RD, 32'h0003_0020);
      rd(ddr_host_pkg::RLO_OFS, q);
      `CHK(q, 32'hDDCCBBAA)
      mdl.lat = 3000;
      cmd_wait(ddr_host_pkg::C_RD, 32'h0003_1410);
      rd(ddr_host_pkg::RLO_OFS, q);
      `CHK(q, 32'h33EE1100)
      rd(ddr_host_pkg::RHI_OFS, q);
      `CHK(q, 32'h77665544)
      `CHK(mdl.open_b, 8'h02)
      cmd_wait(ddr_host_pkg::C_ACT, 32'h0006_0055);
      cmd_wait(ddr_host_pkg::C_PRE, 32'h0001_0000);
      `CHK(mdl.open_b, 8'h40)
      cmd_wait(ddr_host_pkg::C_PRE, 32'h0000_0400);
      `CHK(mdl.open_b, 8'h00)
      rd(8'h24, q);
      `CHK(q, 32'h0)
      // clock enable low: device must ignore the next activate
      wr(ddr_host_pkg::CTRL_OFS, 32'h1);
      repeat (20) @(posedge hclk);
      `CHK({mdl.term_on, mdl.pd}, 2'b01)
      cmd_wait(ddr_host_pkg::C_ACT, 32'h0002_0001);
      `CHK(mdl.open_b, 8'h00)
      wr(ddr_host_pkg::CTRL_OFS, 32'h0);
      repeat (4) @(posedge hclk);
      `CHK(mdl.mr[2], 16'h0)
      // bus reset mid-run: pins drop back at once, bus works after release
      wr(ddr_host_pkg::CTRL_OFS, 32'h7);
      @(posedge hclk);
      `CHK({mem_reset_n, cke, odt}, 3'b111)
      hresetn <= 1'b0;
      #10;
      `CHK({mem_reset_n, cke, odt, cs_n}, 4'b0001)
      @(posedge hclk);
      hresetn <= 1'b1;
      rd(ddr_host_pkg::CTRL_OFS, q);
      `CHK(q, 32'h0)
      stop_test();
   end
endmodule
